// ### verilog/isa_master.sv
// Permanent master of the 16-bit stackable expansion bus.
// Assumes the pin wrapper resolves tri-state and open-collector wires.
`include "isa_params.svh"

module isa_master #(
    parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_MS * `CLK_SYS_KHZ
) (
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    input  wire logic              clk_link_i,
    input  wire logic              req_i,
    input  wire isa_pkg::cmd_t     cmd_i,
    input  wire logic              watchdog_i,
    input  wire logic [15:0]       irq_attached_i,
    input  wire isa_pkg::bus_in_t  bus_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic [15:0]            rdata_o,
    output logic                   resetdrv_o,
    output logic                   nmi_o,
    output logic [15:0]            irq_o,
    output logic [7:0]             drq_o,
    output isa_pkg::bus_out_t      bus_o
);

    localparam isa_pkg::bus_out_t BUS_IDLE = '{
        ior_n: 1'h1, iow_n: 1'h1, memr_n: 1'h1, memw_n: 1'h1,
        smemr_n: 1'h1, smemw_n: 1'h1, sbhe_n: 1'h1, ctl_oe: 1'h1,
        dack_n: `DACK_IDLE, default: '0
    };

    isa_pkg::sys_t  sys_q;
    isa_pkg::sys_t  sys_d;
    isa_pkg::link_t link_q;
    isa_pkg::link_t link_d;

    // System clock side: command port, reset drive, slow bus inputs
    always_comb begin
        sys_d        = sys_q;
        sys_d.irq_s1 = bus_i.irq;
        sys_d.irq_s2 = sys_q.irq_s1;
        sys_d.drq_s1 = bus_i.drq;
        sys_d.drq_s2 = sys_q.drq_s1;
        sys_d.chk_s1 = bus_i.iochck_n;
        sys_d.chk_s2 = sys_q.chk_s1;
        sys_d.ack_s1 = link_q.ack_tgl;
        sys_d.ack_s2 = sys_q.ack_s1;
        sys_d.ack_s3 = sys_q.ack_s2;
        // Pulled-up lines read high when empty, so mask them
        sys_d.irq_out = sys_q.irq_s2 & irq_attached_i;
        sys_d.drq_out = sys_q.drq_s2 & `DRQ_CHAN_MASK;
        sys_d.nmi     = ~sys_q.chk_s2;
        sys_d.done    = 1'h0;
        if (watchdog_i) begin
            sys_d.resetdrv = 1'h1;
            sys_d.rst_cnt  = '0;
        end else if (sys_q.resetdrv) begin
            if (sys_q.rst_cnt == 23'(RESET_HOLD_CYC - 1)) begin
                sys_d.resetdrv = 1'h0;
            end else begin
                sys_d.rst_cnt = sys_q.rst_cnt + 23'h1;
            end
        end
        if (sys_q.ack_s2 != sys_q.ack_s3) begin
            // Link holds its read data until the next request
            sys_d.busy  = 1'h0;
            sys_d.done  = 1'h1;
            sys_d.rdata = link_q.rdata;
        end else if (req_i && !sys_q.busy && !sys_q.resetdrv) begin
            sys_d.cmd     = cmd_i;
            sys_d.busy    = 1'h1;
            sys_d.req_tgl = ~sys_q.req_tgl;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sys_q <= '{resetdrv: 1'h1, cmd: '{kind: isa_pkg::K_MEM, default: '0},
                       default: '0};
        end else begin
            sys_q <= sys_d;
        end
    end

    // Link clock side: bus clocks and the cycle engine
    always_comb begin
        isa_pkg::cmd_t c;
        logic          tick;
        logic          dma;
        logic          mem;
        logic          rd;
        logic          wide;
        logic          fin;
        logic [3:0]    need;
        c      = sys_q.cmd;
        link_d = link_q;
        tick   = 1'h0;
        fin    = 1'h0;
        dma    = (c.kind == isa_pkg::K_DMA);
        mem    = (c.kind == isa_pkg::K_MEM);
        // Master is the data source when rd is low
        rd     = dma ? c.write : ~c.write;
        wide   = dma ? (c.chan >= `DMA_WIDE_CHAN) : c.word;
        need   = link_q.cs16 ? `CMD_TICKS_16 : `CMD_TICKS_8;

        link_d.in_s1 = '{sd: bus_i.sd, iochrdy: bus_i.iochrdy, zws_n: bus_i.zws_n,
                         iocs16_n: bus_i.iocs16_n, memcs16_n: bus_i.memcs16_n};
        link_d.in_s2  = link_q.in_s1;
        link_d.req_s1 = sys_q.req_tgl;
        link_d.req_s2 = link_q.req_s1;
        link_d.req_s3 = link_q.req_s2;
        link_d.bus.ctl_oe = 1'h1;

        // Bus clock rate is set by the divider; keep it at or below 16 MHz
        if (link_q.div == `SYSCLK_HALF - 4'h1) begin
            link_d.div        = '0;
            link_d.bus.sysclk = ~link_q.bus.sysclk;
            tick              = ~link_q.bus.sysclk;
        end else begin
            link_d.div = link_q.div + 4'h1;
        end
        if (link_q.odiv == `OSC_HALF - 4'h1) begin
            link_d.odiv    = '0;
            link_d.bus.osc = ~link_q.bus.osc;
        end else begin
            link_d.odiv = link_q.odiv + 4'h1;
        end

        case (link_q.st)
            isa_pkg::L_IDLE: begin
                if (link_q.req_s2 != link_q.req_s3) begin
                    link_d.second     = 1'h0;
                    link_d.cnt        = '0;
                    link_d.bus.sa     = c.addr[19:0];
                    link_d.bus.la     = c.addr[23:17];
                    link_d.bus.la_oe  = ~(c.kind == isa_pkg::K_IO);
                    link_d.bus.sbhe_n = ~(wide | c.addr[0]);
                    link_d.bus.bale   = 1'h1;
                    link_d.bus.aen    = dma;
                    if (dma) begin
                        link_d.bus.dack_n[c.chan] = 1'h0;
                    end
                    link_d.st = isa_pkg::L_ADDR;
                end
            end
            isa_pkg::L_ADDR: begin
                if (link_q.cnt != `CNT_SAT) begin
                    link_d.cnt = link_q.cnt + 4'h1;
                end
                // Size acknowledge crosses two flops; sampling earlier sees the old level
                if (tick && link_q.cnt >= `CS16_SETTLE) begin
                    // Falling BALE latches the address; DMA keeps it high
                    link_d.bus.bale = dma;
                    if (dma) begin
                        link_d.cs16 = wide;
                    end else if (mem) begin
                        link_d.cs16 = ~link_q.in_s2.memcs16_n;
                    end else begin
                        link_d.cs16 = ~link_q.in_s2.iocs16_n;
                    end
                    if (dma) begin
                        link_d.bus.ior_n  = ~c.write;
                        link_d.bus.iow_n  = c.write;
                        link_d.bus.memw_n = ~c.write;
                        link_d.bus.memr_n = c.write;
                    end else if (mem) begin
                        link_d.bus.memr_n = ~rd;
                        link_d.bus.memw_n = rd;
                    end else begin
                        link_d.bus.ior_n = ~rd;
                        link_d.bus.iow_n = rd;
                    end
                    if ((mem || dma) && c.addr[23:20] == `SMEM_PAGE) begin
                        link_d.bus.smemr_n = link_d.bus.memr_n;
                        link_d.bus.smemw_n = link_d.bus.memw_n;
                    end
                    link_d.bus.tc = dma & c.tc;
                    if (link_q.second) begin
                        link_d.bus.sd = {c.wdata[15:8], c.wdata[15:8]};
                    end else if (wide) begin
                        link_d.bus.sd = c.wdata;
                    end else begin
                        // Byte copied to both lanes so 8-bit cards see it too
                        link_d.bus.sd = {c.wdata[7:0], c.wdata[7:0]};
                    end
                    link_d.bus.sd_oe = ~rd;
                    link_d.cnt       = '0;
                    link_d.st        = isa_pkg::L_CMD;
                end
            end
            isa_pkg::L_CMD: begin
                if (tick) begin
                    if (link_q.cnt != `CNT_SAT) begin
                        link_d.cnt = link_q.cnt + 4'h1;
                    end
                    if (!link_q.in_s2.iochrdy) begin
                        fin = 1'h0;
                    end else if (mem && !link_q.in_s2.zws_n) begin
                        fin = 1'h1;
                    end else begin
                        fin = ((link_q.cnt + 4'h1) >= need);
                    end
                end
                if (fin) begin
                    if (rd) begin
                        if (link_q.second) begin
                            link_d.rdata[15:8] = link_q.in_s2.sd[7:0];
                        end else if (wide && link_q.cs16) begin
                            link_d.rdata = link_q.in_s2.sd;
                        end else if (!wide && c.addr[0] && link_q.cs16) begin
                            link_d.rdata = {8'h00, link_q.in_s2.sd[15:8]};
                        end else begin
                            link_d.rdata = {8'h00, link_q.in_s2.sd[7:0]};
                        end
                    end
                    link_d.bus.ior_n   = 1'h1;
                    link_d.bus.iow_n   = 1'h1;
                    link_d.bus.memr_n  = 1'h1;
                    link_d.bus.memw_n  = 1'h1;
                    link_d.bus.smemr_n = 1'h1;
                    link_d.bus.smemw_n = 1'h1;
                    link_d.bus.tc      = 1'h0;
                    link_d.st          = isa_pkg::L_END;
                end
            end
            isa_pkg::L_END: begin
                if (tick) begin
                    link_d.bus.sd_oe = 1'h0;
                    if (wide && !link_q.cs16 && !link_q.second) begin
                        // 8-bit target: odd byte follows on the lower lane
                        link_d.second     = 1'h1;
                        link_d.bus.sa[0]  = 1'h1;
                        link_d.bus.sbhe_n = 1'h1;
                        link_d.cnt        = '0;
                        link_d.bus.bale   = 1'h1;
                        link_d.st         = isa_pkg::L_ADDR;
                    end else begin
                        link_d.bus.bale   = 1'h0;
                        link_d.bus.aen    = 1'h0;
                        link_d.bus.dack_n = `DACK_IDLE;
                        link_d.bus.la_oe  = 1'h0;
                        link_d.ack_tgl    = ~link_q.ack_tgl;
                        link_d.st         = isa_pkg::L_IDLE;
                    end
                end
            end
            default: begin
                link_d.st = isa_pkg::L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_link_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_q <= '{st: isa_pkg::L_IDLE, bus: BUS_IDLE, default: '0};
        end else begin
            link_q <= link_d;
        end
    end

    assign busy_o     = sys_q.busy;
    assign done_o     = sys_q.done;
    assign rdata_o    = sys_q.rdata;
    assign resetdrv_o = sys_q.resetdrv;
    assign nmi_o      = sys_q.nmi;
    assign irq_o      = sys_q.irq_out;
    assign drq_o      = sys_q.drq_out;
    assign bus_o      = link_q.bus;

endmodule // isa_master

// ### verilog/isa_params.svh
// Constants for the expansion bus master: times, counts, encodings.
// Assumes inclusion by bare name from the bus master design file.
`ifndef ISA_PARAMS_SVH
`define ISA_PARAMS_SVH
`define CLK_SYS_KHZ    40000
`define RESET_HOLD_MS  100
`define SYSCLK_HALF    4'h6
`define OSC_HALF       4'h6
`define CMD_TICKS_8    4'h4
`define CMD_TICKS_16   4'h2
`define CNT_SAT        4'hf
`define CS16_SETTLE    4'h3
`define SMEM_PAGE      4'h0
`define DMA_WIDE_CHAN  3'h5
`define DACK_IDLE      8'hff
`define DRQ_CHAN_MASK  8'hef
`endif

// ### verilog/isa_pkg.sv
// Types of the expansion bus master: commands, pin groups, state records.
// Assumes nothing beyond a SystemVerilog compiler.
package isa_pkg;
    typedef enum logic [2:0] {
        K_MEM = 3'h1,
        K_IO  = 3'h2,
        K_DMA = 3'h4
    } kind_t;

    typedef enum logic [3:0] {
        L_IDLE = 4'h1,
        L_ADDR = 4'h2,
        L_CMD  = 4'h4,
        L_END  = 4'h8
    } link_state_t;

    typedef struct packed {
        kind_t       kind;
        logic        write;
        logic        word;
        logic        tc;
        logic [2:0]  chan;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic [15:0] sd;
        logic        iochrdy;
        logic        zws_n;
        logic        iocs16_n;
        logic        memcs16_n;
        logic        iochck_n;
        logic [15:0] irq;
        logic [7:0]  drq;
    } bus_in_t;

    typedef struct packed {
        logic [15:0] sd;
        logic        iochrdy;
        logic        zws_n;
        logic        iocs16_n;
        logic        memcs16_n;
    } link_in_t;

    typedef struct packed {
        logic [19:0] sa;
        logic [6:0]  la;
        logic        la_oe;
        logic        sbhe_n;
        logic        bale;
        logic        aen;
        logic        ior_n;
        logic        iow_n;
        logic        memr_n;
        logic        memw_n;
        logic        smemr_n;
        logic        smemw_n;
        logic        ctl_oe;
        logic [7:0]  dack_n;
        logic        tc;
        logic [15:0] sd;
        logic        sd_oe;
        logic        sysclk;
        logic        osc;
    } bus_out_t;

    typedef struct packed {
        link_in_t    in_s1;
        link_in_t    in_s2;
        logic        req_s1;
        logic        req_s2;
        logic        req_s3;
        link_state_t st;
        logic [3:0]  div;
        logic [3:0]  odiv;
        logic [3:0]  cnt;
        logic        second;
        logic        cs16;
        logic        ack_tgl;
        logic [15:0] rdata;
        bus_out_t    bus;
    } link_t;

    typedef struct packed {
        logic [15:0] irq_s1;
        logic [15:0] irq_s2;
        logic [7:0]  drq_s1;
        logic [7:0]  drq_s2;
        logic        chk_s1;
        logic        chk_s2;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_s3;
        logic        req_tgl;
        logic        busy;
        logic        done;
        logic        resetdrv;
        logic        nmi;
        logic [22:0] rst_cnt;
        logic [15:0] irq_out;
        logic [7:0]  drq_out;
        logic [15:0] rdata;
        cmd_t        cmd;
    } sys_t;
endpackage

// ### testbench/isa_master_asserts.sv
// Port checks for the expansion bus master, bound onto the design.
// Assumes the design package; pin checks run on the link clock.
module isa_master_asserts #(
    parameter int unsigned RESET_HOLD_CYC = 20
) (
    input wire logic              clk_sys_i,
    input wire logic              nrst_i,
    input wire logic              clk_link_i,
    input wire logic              req_i,
    input wire logic              watchdog_i,
    input wire logic [15:0]       irq_attached_i,
    input wire isa_pkg::bus_in_t  bus_i,
    input wire logic              busy_o,
    input wire logic              done_o,
    input wire logic              resetdrv_o,
    input wire logic              nmi_o,
    input wire logic [15:0]       irq_o,
    input wire isa_pkg::bus_out_t bus_o
);
    logic [31:0] hold_q;
    logic        io_cmd;
    assign io_cmd = !bus_o.ior_n || !bus_o.iow_n;
    logic        any_cmd;
    assign any_cmd = io_cmd || !bus_o.memr_n || !bus_o.memw_n;
    // Restarts with watchdog so a late restart is judged afresh
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) hold_q <= '0;
        else if (watchdog_i || !resetdrv_o) hold_q <= '0;
        else hold_q <= hold_q + 32'h1;
    end
    sequence s_addr;
        bus_o.bale && !bus_o.aen ##1 !bus_o.bale;
    endsequence
    sequence s_cmd;
        !bus_o.memr_n || !bus_o.memw_n || io_cmd;
    endsequence
    a_addr_then_cmd: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        s_addr |-> ##[0:2] s_cmd) else $error("no command after address strobe");
    a_dma_bale: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        io_cmd && bus_o.aen |-> bus_o.bale) else $error("address strobe low in dma");
    a_dma_aen: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        io_cmd && bus_o.dack_n != 8'hff |-> bus_o.aen) else $error("dma without aen");
    a_io_no_la: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        io_cmd && !bus_o.aen |-> !bus_o.la_oe) else $error("upper address driven for io");
    a_smem_low_mb: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        !bus_o.smemr_n |-> !bus_o.memr_n && (!bus_o.la_oe || bus_o.la[6:3] == 4'h0))
        else $error("short memory read outside first megabyte");
    a_dack_single: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        $countones(~bus_o.dack_n) <= 1 && bus_o.dack_n[4]) else $error("bad acknowledge set");
    a_odd_copy: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        (!bus_o.memw_n || !bus_o.iow_n) && bus_o.sd_oe && !bus_o.aen && !bus_o.sbhe_n
        && bus_o.sa[0] |-> bus_o.sd[15:8] == bus_o.sd[7:0]) else $error("odd byte lanes differ");
    a_irq_mask: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $stable(irq_attached_i) |-> (irq_o & ~irq_attached_i) == 16'h0)
        else $error("unattached request passed");
    a_nmi_sync: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !bus_i.iochck_n [*4] |-> ##1 nmi_o) else $error("bus error not raised");
    a_reset_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(resetdrv_o) |-> hold_q >= RESET_HOLD_CYC - 1) else $error("reset drive too short");
    a_watchdog: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        watchdog_i |=> resetdrv_o) else $error("watchdog did not restart reset drive");
    a_accept: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(busy_o) |-> $past(req_i) && !$past(resetdrv_o)) else $error("bad accept");
    a_done_end: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        done_o |-> !busy_o && $past(busy_o) ##1 !done_o) else $error("bad completion pulse");
    a_ready_stretch: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        (any_cmd && !bus_i.iochrdy) [*3] |=> any_cmd) else $error("cycle ended while not ready");
    a_tc_strobe: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        bus_o.tc |-> bus_o.aen && io_cmd && bus_o.dack_n != 8'hff)
        else $error("terminal count outside dma command");
    a_sysclk_run: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        bus_o.sysclk |-> ##6 !bus_o.sysclk) else $error("bus clock high too long");
    a_osc_run: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        bus_o.osc |-> ##6 !bus_o.osc) else $error("oscillator clock high too long");
endmodule // isa_master_asserts

bind isa_master isa_master_asserts #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_link_i(clk_link_i), .req_i(req_i),
    .watchdog_i(watchdog_i), .irq_attached_i(irq_attached_i), .bus_i(bus_i), .busy_o(busy_o),
    .done_o(done_o), .resetdrv_o(resetdrv_o), .nmi_o(nmi_o), .irq_o(irq_o), .bus_o(bus_o));

// ### testbench/isa_adapter_model.sv
// Adapter board model on the far side of the expansion bus.
// Assumes the bench resolves the data lines and feeds them back.
module isa_adapter_model (
    input  wire logic              clk_i,
    input  wire logic              rst_drv_i,
    input  wire logic              wide_i,
    input  wire logic              zws_i,
    input  wire logic [3:0]        wait_i,
    input  wire logic [15:0]       sd_i,
    input  wire isa_pkg::bus_out_t pins_i,
    output isa_pkg::link_in_t      pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  mem [256];
    logic [7:0]  a;
    logic [3:0]  wcnt = 4'h0;
    logic [15:0] rd;
    logic [15:0] last = 16'h0;
    logic        strb;
    logic        drv;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    assign a = pins_i.sa[7:0];
    assign strb = !(pins_i.memr_n && pins_i.memw_n && pins_i.ior_n && pins_i.iow_n);
    // Quiet in reset; I/O reply only outside dma or when acknowledged
    assign drv = !rst_drv_i && !pins_i.sd_oe && (!pins_i.memr_n || (!pins_i.ior_n
                 && (!pins_i.aen || pins_i.dack_n != 8'hff)));
    assign rd = wide_i ? {mem[a | 8'h01], mem[a & 8'hfe]} : {~mem[a], mem[a]};
    // Released lines show the inverse of the last value, never a stale copy
    assign pins_o = '{sd: drv ? rd : ~last, iochrdy: !(strb && wcnt != 4'h0),
                      zws_n: !(zws_i && wide_i && !(pins_i.memr_n && pins_i.memw_n)),
                      iocs16_n: !(wide_i && !pins_i.aen),
                      memcs16_n: !(wide_i && pins_i.la_oe)};
    always @(posedge clk_i) begin
        wcnt <= strb ? (wcnt == 4'h0 ? 4'h0 : wcnt - 4'h1) : wait_i;
        if (drv) last <= rd;
        if (!rst_drv_i && (!pins_i.memw_n || !pins_i.iow_n)) begin
            mem[a] <= (wide_i && pins_i.sa[0]) ? sd_i[15:8] : sd_i[7:0];
            if (wide_i && !pins_i.sa[0] && !pins_i.sbhe_n) mem[a | 8'h01] <= sd_i[15:8];
        end
    end
endmodule // isa_adapter_model

// ### testbench/stackable_16bit_expansion_bus_tb.sv
// Self-checking bench for the expansion bus master and an adapter model.
// Assumes design files, checker and adapter model are compiled first.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module stackable_16bit_expansion_bus_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned HOLD = 20;
    logic              clk_sys_i = 1'b0, clk_link_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0;
    logic              watchdog_i = 1'b0, wide = 1'b0, zws = 1'b0, chk_n = 1'b1;
    logic [3:0]        wt = 4'h0;
    logic [15:0]       irq_attached_i = 16'h0, irq_raw = 16'h0, rdata_o, irq_o, wd;
    logic [7:0]        drq_raw = 8'h0, drq_o, a;
    logic [23:0]       ad;
    logic              busy_o, done_o, resetdrv_o, nmi_o;
    logic [7:0]        ref_mem [256];
    isa_pkg::cmd_t     cmd_i = '0;
    isa_pkg::bus_in_t  bus_i;
    isa_pkg::link_in_t lnk;
    isa_pkg::bus_out_t bus_o;
    int                miscompares = 0, n_checks = 0, i, n;
    always #12.5 clk_sys_i = ~clk_sys_i;
    always #3 clk_link_i = ~clk_link_i;
    assign bus_i = '{sd: bus_o.sd_oe ? bus_o.sd : lnk.sd, iochrdy: lnk.iochrdy, zws_n: lnk.zws_n,
                     iocs16_n: lnk.iocs16_n, memcs16_n: lnk.memcs16_n, iochck_n: chk_n,
                     irq: irq_raw, drq: drq_raw};
    isa_master #(.RESET_HOLD_CYC(HOLD)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .clk_link_i(clk_link_i), .req_i(req_i), .cmd_i(cmd_i), .watchdog_i(watchdog_i),
        .irq_attached_i(irq_attached_i), .bus_i(bus_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o), .resetdrv_o(resetdrv_o), .nmi_o(nmi_o), .irq_o(irq_o),
        .drq_o(drq_o), .bus_o(bus_o));
    isa_adapter_model u_adp (.clk_i(clk_link_i), .rst_drv_i(resetdrv_o), .wide_i(wide),
        .zws_i(zws), .wait_i(wt), .sd_i(bus_i.sd), .pins_i(bus_o), .pins_o(lnk));
    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Holds the request only for the accepting edge, then waits bounded
    task automatic xfer(input isa_pkg::kind_t k, input logic wr, input logic [2:0] ch,
                        input logic [23:0] adr, input logic [15:0] dat, input logic wrd);
        int m;
        cmd_i = '{kind: k, write: wr, word: wrd, tc: 1'b1, chan: ch, addr: adr, wdata: dat};
        req_i = 1'b1;
        tick();
        req_i = 1'b0;
        for (m = 0; done_o !== 1'b1 && m < 3000; m++) tick();
        if (m >= 3000) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    initial begin
        for (i = 0; i < 256; i++) ref_mem[i] = 8'(i);
        n = $urandom(83653);
        repeat (10) tick();
        nrst_i = 1'b1;
        for (n = 0; resetdrv_o === 1'b1 && n < 100; n++) tick();
        `CHK(n >= HOLD - 1 && n <= HOLD + 1, 1'b1)
        $display("reset hold test done");
        for (i = 0; i < 16; i++) begin
            wide = i[1];
            zws = i[2];
            wt = 4'($urandom % 16);
            ad = 24'($urandom) & (i[0] ? 24'h00fffe : 24'hfffffe);
            wd = 16'($urandom);
            a = ad[7:0];
            xfer(i[0] ? isa_pkg::K_IO : isa_pkg::K_MEM, 1'b1, 3'h0, ad, wd, 1'b1);
            ref_mem[a] = wd[7:0];
            ref_mem[a + 8'h01] = wd[15:8];
            xfer(i[0] ? isa_pkg::K_IO : isa_pkg::K_MEM, 1'b0, 3'h0, ad, 16'h0, 1'b1);
            `CHK(rdata_o, {ref_mem[a + 8'h01], ref_mem[a]})
            a = a | {7'h0, i[3]};
            xfer(i[0] ? isa_pkg::K_IO : isa_pkg::K_MEM, 1'b1, 3'h0, ad | i[3], ~wd, 1'b0);
            ref_mem[a] = ~wd[7:0];
            xfer(i[0] ? isa_pkg::K_IO : isa_pkg::K_MEM, 1'b0, 3'h0, ad | i[3], 16'h0, 1'b0);
            `CHK(rdata_o[7:0], ref_mem[a])
        end
        $display("memory and io test done");
        wide = 1'b1;
        for (i = 0; i < 8; i++) begin
            if (i != 4) begin
                ad = 24'($urandom) & 24'h0ffffe;
                a = ad[7:0];
                wd = {i >= 5 ? 8'($urandom) : ref_mem[a + 8'h01], 8'($urandom)};
                xfer(isa_pkg::K_DMA, 1'b0, i[2:0], ad, wd, 1'b0);
                ref_mem[a] = wd[7:0];
                ref_mem[a + 8'h01] = wd[15:8];
                xfer(isa_pkg::K_DMA, 1'b1, i[2:0], ad, 16'h0, 1'b0);
                `CHK(rdata_o[7:0], ref_mem[a])
                if (i >= 5) `CHK(rdata_o[15:8], ref_mem[a + 8'h01])
            end
        end
        $display("dma test done");
        for (i = 0; i < 8; i++) begin
            irq_attached_i = 16'($urandom);
            irq_raw = 16'($urandom);
            drq_raw = 8'($urandom);
            repeat (4) tick();
            `CHK(irq_o, irq_raw & irq_attached_i)
            `CHK(drq_o, drq_raw & 8'hef)
        end
        chk_n = 1'b0;
        repeat (4) tick();
        `CHK(nmi_o, 1'b1)
        chk_n = 1'b1;
        repeat (4) tick();
        `CHK(nmi_o, 1'b0)
        $display("request line test done");
        watchdog_i = 1'b1;
        tick();
        watchdog_i = 1'b0;
        `CHK(resetdrv_o, 1'b1)
        for (n = 1; resetdrv_o === 1'b1 && n < 100; n++) tick();
        `CHK(n >= HOLD - 1 && n <= HOLD + 1, 1'b1)
        $display("watchdog test done");
        report_and_stop();
    end
endmodule // stackable_16bit_expansion_bus_tb
